// [logic/ntu_act_sm.sv]
// NT-side U activation state machine with its line, indication and activity outputs.
// Operation
// - B+B+D all ones outside data states
// - Line sync signal chooses transparent variant correctly
// - Activation indications, loop variants under loopback
// - Pending deactivation states hold activity bit
// - Downstream activity zero on DI or TIM
// - Alerting from Deactivated gives PU, else DC
// - Alerting sends NT tone for tone timer
// - Tone in Receive Reset, incomplete deactivation: Alerting 1
// - Power-down only in Deactivated; awaked stays powered
// - EC training sends SN1, freezes adaptation
// - EC-Training 1 when deactivation unfinished
// - Downstream error: Error S/T, activity zero
// - U_ONLY_ACTIVATION_BIT zero after activation: pending S/T, DR
// - Pending U waits for short signal loss
// - Framing loss or supervision: silence, await loss
// - Pending timing issues DC four frames
// - Receive Reset resets receiver unless entered from Pending U; hold timer blocks
// - U_ONLY_ACTIVATION_BIT one enters Synchronized 2
// - Single pulses while SEND_SINGLE_PULSES_CMD command applied
// - Wait for ACT one, then Transparent
// - Wait for SF sends training signal two
// - Simplified mode indication changes
// - Simplified mode transition changes
// - Short signal loss after 3 ms
`include "ntu_defs.svh"
module ntu_act_sm
  import ntu_pkg::*;
#(
  parameter int unsigned LSU_CYCLES   = `NTU_LSU_TIME_US * `NTU_CLK_MHZ,
  parameter int unsigned FRAME_CYCLES = `NTU_FRAME_TIME_US * `NTU_CLK_MHZ,
  parameter int unsigned TONE_CYCLES  = `NTU_TONE_TIME_US * `NTU_CLK_MHZ,
  parameter int unsigned HOLD_CYCLES  = `NTU_HOLD_TIME_US * `NTU_CLK_MHZ,
  parameter int unsigned SUPV_CYCLES  = `NTU_SUPV_TIME_US * `NTU_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Avalon-MM register slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Line receive criteria (asynchronous)
  input  wire logic        lt_wake_tone_in,
  input  wire logic        signal_level_in,
  input  wire logic        framing_loss_in,
  input  wire logic        ec_converged_in,
  input  wire logic        lt_training_in,
  input  wire logic        superframe_in,
  input  wire logic        u_only_activation_bit_in,
  input  wire logic        act_bit_rx_in,
  input  wire logic        lt_deact_in,
  input  wire logic        loopback_b_channels_in,
  // Frame bus control channel (asynchronous)
  input  wire logic [3:0]  ds_cmd_in,
  // Line and frame bus outputs
  output ntu_line_t        line_signal_out,
  output logic [3:0]       ci_ind_out,
  output logic             activity_bit_out,
  output logic             downstream_activity_bit_out,
  output logic             data_all_ones_out,
  output logic             power_down_out,
  output logic             rx_reset_out,
  output logic             adapt_freeze_out
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  // The command code is sampled as a group; it stays put for whole frames, far longer than the two-cycle lag.
  logic [13:0] sync_q;
  logic        wake_s, level_s, lof_s, ecc_s, ltt_s, sf_s, uoa_s, actrx_s, ltdeact_s, loopback_b_channels_cmd_s;
  logic [3:0]  cmd_s;

  ntu_sync #(.W(14)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       ({ds_cmd_in, loopback_b_channels_in, lt_deact_in, act_bit_rx_in, u_only_activation_bit_in,
                  superframe_in, lt_training_in, ec_converged_in, framing_loss_in, signal_level_in,
                  lt_wake_tone_in}),
    .q_out      (sync_q)
  );

  assign {cmd_s, loopback_b_channels_cmd_s, ltdeact_s, actrx_s, uoa_s, sf_s, ltt_s, ecc_s, lof_s, level_s, wake_s} = sync_q;

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic [7:0]  ctrl_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_w;
  ntu_state_t  state_reg;
  ntu_state_t  state_next;
  logic        tseen_reg;
  logic        lsu_reg;
  logic        simp;
  logic        req;

  assign simp = ctrl_reg[`NTU_CTRL_SIMPLIFIED];
  assign req  = avs_read_in | avs_write_in;

  always_comb begin
    status_w                                      = 32'h0;
    status_w[`NTU_ST_STATE_LSB +: 5]              = state_reg;
    status_w[`NTU_ST_CI_LSB +: 4]                 = ci_ind_out;
    status_w[`NTU_ST_LINE_LSB +: 3]               = line_signal_out;
    status_w[`NTU_ST_ACT]                         = activity_bit_out;
    status_w[`NTU_ST_SAI]                         = downstream_activity_bit_out;
    status_w[`NTU_ST_TSEEN]                       = tseen_reg;
    status_w[`NTU_ST_LSU]                         = lsu_reg;
  end

  // One wait cycle per access: the request is seen with waitrequest high, answered on the next edge.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(req && wait_reg);
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h0;
    end else if (avs_read_in && wait_reg) begin
      unique case (avs_address_in)
        `NTU_OFS_CTRL:   rdata_reg <= {24'h0, ctrl_reg};
        `NTU_OFS_STATUS: rdata_reg <= status_w;
        default:         rdata_reg <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= `NTU_CTRL_RESET;
    end else if (avs_write_in && !wait_reg && avs_address_in == `NTU_OFS_CTRL && avs_byteenable_in[0]) begin
      ctrl_reg <= avs_writedata_in[7:0];
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  // ****************************************************************
  // Short signal loss detector
  // ****************************************************************
  logic [31:0] lsu_cnt_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lsu_cnt_reg <= 32'h0;
      lsu_reg     <= 1'b0;
    end else if (level_s) begin
      lsu_cnt_reg <= 32'h0;
      lsu_reg     <= 1'b0;
    end else if (lsu_cnt_reg < LSU_CYCLES - 1) begin
      lsu_cnt_reg <= lsu_cnt_reg + 32'h1;
    end else begin
      lsu_reg     <= 1'b1;
    end
  end

  // ****************************************************************
  // Timers
  // ****************************************************************
  // One per-state timer is reloaded on every state change; supervision runs from Alerting through Wait for SF.
  logic [31:0] stim_reg;
  logic [31:0] supv_reg;
  logic [2:0]  frames_reg;
  logic        entered;
  logic        stim_done;
  logic        supv_done;
  logic        activating;

  assign entered    = state_next != state_reg;
  assign stim_done  = stim_reg == 32'h0;
  assign supv_done  = supv_reg == 32'h0;
  assign activating = state_reg inside {ntu_alert, ntu_alert1, ntu_ec_train, ntu_ec_train1, ntu_eq_train,
                                        ntu_wait_sf};

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stim_reg   <= 32'h0;
      frames_reg <= 3'h0;
    end else if (entered) begin
      unique case (state_next)
        ntu_alert:    stim_reg <= TONE_CYCLES;
        ntu_rx_reset: stim_reg <= HOLD_CYCLES;
        default:      stim_reg <= FRAME_CYCLES;
      endcase
      frames_reg <= 3'h0;
    end else if (!stim_done) begin
      stim_reg <= stim_reg - 32'h1;
    end else if (state_reg == ntu_pend_tim) begin
      stim_reg   <= FRAME_CYCLES;
      frames_reg <= frames_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      supv_reg <= 32'h0;
    end else if (!activating) begin
      supv_reg <= SUPV_CYCLES;
    end else if (!supv_done) begin
      supv_reg <= supv_reg - 32'h1;
    end
  end

  // ****************************************************************
  // State machine
  // ****************************************************************
  logic cmd_di;
  logic cmd_tim;
  logic deact_done;
  logic from_pend_u_reg;

  assign cmd_di     = cmd_s == `NTU_CMD_DI;
  assign cmd_tim    = cmd_s == `NTU_CMD_TIM;
  assign deact_done = cmd_di || (simp && cmd_tim);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ntu_reset: begin
        if (simp && cmd_tim) state_next = ntu_awaked;
        else if (cmd_di) state_next = ntu_deact;
      end
      ntu_deact, ntu_awaked: begin
        if (wake_s || cmd_s == `NTU_CMD_AR || ctrl_reg[`NTU_CTRL_NT_ACT]) state_next = ntu_alert;
        else if (cmd_tim) state_next = ntu_awaked;
        else if (cmd_di) state_next = ntu_deact;
      end
      ntu_alert:       if (stim_done) state_next = ntu_ec_train;
      ntu_alert1:      if (deact_done) state_next = ntu_alert;
      ntu_ec_train:    if (ecc_s) state_next = ntu_eq_train;
      ntu_ec_train1:   if (deact_done) state_next = ntu_ec_train;
      ntu_eq_train:    if (ltt_s) state_next = ntu_wait_sf;
      ntu_wait_sf:     if (sf_s) state_next = ntu_sync1;
      ntu_sync1:       if (uoa_s) state_next = ntu_sync2;
      ntu_sync2: begin
        if (!uoa_s) state_next = ntu_sync1;
        else if (cmd_s == `NTU_CMD_AI) state_next = ntu_wait_act;
      end
      ntu_wait_act:    if (actrx_s) state_next = ntu_transp;
      ntu_transp: begin
        if (cmd_s == `NTU_CMD_EI1) state_next = ntu_err_st;
        else if (!uoa_s) state_next = ntu_pend_st;
      end
      ntu_err_st:      if (cmd_s != `NTU_CMD_EI1) state_next = ntu_sync2;
      ntu_pend_st:     if (deact_done) state_next = ntu_sync1;
      ntu_pend_u:      if (lsu_reg) state_next = ntu_rx_reset;
      ntu_pend_rxr:    if (lsu_reg) state_next = ntu_rx_reset;
      ntu_rx_reset: begin
        if (wake_s) state_next = cmd_di ? ntu_alert : ntu_alert1;
        else if (ltt_s) state_next = cmd_di ? ntu_ec_train : ntu_ec_train1;
        else if (stim_done && simp && cmd_tim) state_next = ntu_awaked;
        else if (stim_done && cmd_di) state_next = ntu_pend_tim;
      end
      ntu_pend_tim:    if (frames_reg == 3'(`NTU_DC_FRAMES)) state_next = ntu_deact;
      ntu_test:        if (cmd_s != `NTU_CMD_SSP) state_next = ntu_deact;
      ntu_ec_train_al: if (ecc_s) state_next = ntu_wait_sf_al;
      ntu_wait_sf_al:  if (sf_s) state_next = ntu_ana_loop;
      ntu_ana_loop:    if (!ctrl_reg[`NTU_CTRL_ANA_LOOP]) state_next = ntu_reset;
      default:         state_next = ntu_reset;
    endcase
    // Unconditional entries take priority over every local transition.
    if (ctrl_reg[`NTU_CTRL_SOFT_RST]) begin
      state_next = ntu_reset;
    end else if (ctrl_reg[`NTU_CTRL_ANA_LOOP] && state_reg inside {ntu_reset, ntu_deact, ntu_awaked}) begin
      state_next = ntu_ec_train_al;
    end else if (cmd_s == `NTU_CMD_SSP && state_reg inside {ntu_reset, ntu_deact, ntu_awaked}) begin
      state_next = ntu_test;
    end else if ((lof_s && state_reg inside {ntu_sync1, ntu_sync2, ntu_wait_act, ntu_transp, ntu_err_st,
                                            ntu_pend_st})
                 || (activating && supv_done)) begin
      state_next = ntu_pend_rxr;
    end else if (ltdeact_s && state_reg inside {ntu_sync1, ntu_sync2, ntu_wait_act, ntu_transp, ntu_err_st,
                                                 ntu_pend_st}) begin
      state_next = ntu_pend_u;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ntu_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      from_pend_u_reg <= 1'b0;
    end else if (entered && state_next == ntu_rx_reset) begin
      from_pend_u_reg <= state_reg == ntu_pend_u;
    end
  end

  // Transparent reached during this activation; forgotten once the line drops back to reset states.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tseen_reg <= 1'b0;
    end else if (state_next == ntu_transp) begin
      tseen_reg <= 1'b1;
    end else if (state_next inside {ntu_reset, ntu_deact, ntu_awaked, ntu_rx_reset, ntu_pend_tim}) begin
      tseen_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  ntu_line_t  line_next;
  logic [3:0] ci_next;
  logic       act_next;
  logic       sync3_sel;

  assign sync3_sel = loopback_b_channels_cmd_s || tseen_reg || state_next == ntu_transp;

  always_comb begin
    line_next = ntu_ls_silence;
    unique case (state_next)
      ntu_alert, ntu_alert1:                   line_next = ntu_ls_nt_tone;
      ntu_ec_train, ntu_ec_train1, ntu_ec_train_al,
      ntu_eq_train:                            line_next = ntu_ls_train1;
      ntu_wait_sf, ntu_wait_sf_al:             line_next = ntu_ls_train2;
      ntu_sync1, ntu_sync2, ntu_wait_act, ntu_transp, ntu_err_st, ntu_pend_st,
      ntu_ana_loop:                            line_next = sync3_sel ? ntu_ls_sync3t : ntu_ls_sync3;
      ntu_test:                                line_next = ntu_ls_pulses;
      default:                                 line_next = ntu_ls_silence;
    endcase
  end

  always_comb begin
    ci_next = `NTU_IND_DC;
    unique case (state_next)
      ntu_reset, ntu_rx_reset:                  ci_next = `NTU_IND_DR;
      ntu_alert: begin
        if (simp || (entered && state_reg == ntu_deact)) ci_next = `NTU_IND_PU;
        else if (entered) ci_next = `NTU_IND_DC;
        else ci_next = ci_ind_out;
      end
      ntu_ec_train, ntu_eq_train, ntu_wait_sf, ntu_sync1:
        ci_next = simp ? `NTU_IND_PU : `NTU_IND_DC;
      ntu_pend_rxr:                             ci_next = simp ? `NTU_IND_DR : `NTU_IND_EI1;
      ntu_pend_u, ntu_wait_sf_al, ntu_ec_train_al:
        ci_next = simp ? `NTU_IND_DR : `NTU_IND_DC;
      ntu_sync2, ntu_wait_act, ntu_err_st:      ci_next = loopback_b_channels_cmd_s ? `NTU_IND_ARL : `NTU_IND_AR;
      ntu_transp:                               ci_next = loopback_b_channels_cmd_s ? `NTU_IND_AIL : `NTU_IND_AI;
      ntu_pend_st:                              ci_next = `NTU_IND_DR;
      ntu_test, ntu_ana_loop:                   ci_next = `NTU_IND_PU;
      default:                                  ci_next = `NTU_IND_DC;
    endcase
  end

  always_comb begin
    unique case (state_next)
      ntu_wait_act, ntu_transp:  act_next = 1'b1;
      ntu_pend_st, ntu_pend_u:   act_next = activity_bit_out;
      default:                   act_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_signal_out  <= ntu_ls_silence;
      ci_ind_out       <= `NTU_IND_DR;
      activity_bit_out <= 1'b0;
    end else begin
      line_signal_out  <= line_next;
      ci_ind_out       <= ci_next;
      activity_bit_out <= act_next;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      downstream_activity_bit_out <= 1'b0;
      data_all_ones_out           <= 1'b1;
      power_down_out              <= 1'b0;
      rx_reset_out                <= 1'b0;
      adapt_freeze_out            <= 1'b0;
    end else begin
      downstream_activity_bit_out <= !(cmd_di || cmd_tim);
      data_all_ones_out           <= !(state_next inside {ntu_transp, ntu_ana_loop});
      power_down_out              <= state_next == ntu_deact;
      rx_reset_out                <= state_next == ntu_rx_reset
                                     && !(entered ? state_reg == ntu_pend_u : from_pend_u_reg);
      adapt_freeze_out            <= state_next inside {ntu_ec_train, ntu_ec_train1, ntu_ec_train_al};
    end
  end

endmodule : ntu_act_sm

// [logic/ntu_defs.svh]
// Constants for the NT-side U activation state machine: register map, field positions, codes and timing.
`ifndef NTU_DEFS_SVH
`define NTU_DEFS_SVH

// ****************************************************************
// Register map (byte offsets) and fields
// ****************************************************************
`define NTU_ADDR_W          4
`define NTU_OFS_CTRL        4'h0
`define NTU_OFS_STATUS      4'h4
`define NTU_CTRL_RESET      8'h00
`define NTU_CTRL_SIMPLIFIED 0
`define NTU_CTRL_NT_ACT     1
`define NTU_CTRL_SOFT_RST   2
`define NTU_CTRL_ANA_LOOP   3
`define NTU_ST_STATE_LSB    0
`define NTU_ST_CI_LSB       8
`define NTU_ST_LINE_LSB     16
`define NTU_ST_ACT          20
`define NTU_ST_SAI          21
`define NTU_ST_TSEEN        22
`define NTU_ST_LSU          23

// ****************************************************************
// Command and indication codes on the frame bus control channel
// ****************************************************************
`define NTU_CMD_TIM         4'h0
`define NTU_CMD_SSP         4'h2
`define NTU_CMD_EI1         4'h6
`define NTU_CMD_AR          4'h8
`define NTU_CMD_AI          4'hc
`define NTU_CMD_DI          4'hf
`define NTU_IND_DR          4'h0
`define NTU_IND_EI1         4'h6
`define NTU_IND_PU          4'h7
`define NTU_IND_AR          4'h8
`define NTU_IND_ARL         4'ha
`define NTU_IND_AI          4'hc
`define NTU_IND_AIL         4'he
`define NTU_IND_DC          4'hf

// ****************************************************************
// Timing
// ****************************************************************
`define NTU_CLK_MHZ         200
`define NTU_LSU_TIME_US     3000
`define NTU_FRAME_TIME_US   125
`define NTU_DC_FRAMES       4
`define NTU_TONE_TIME_US    1000
`define NTU_HOLD_TIME_US    2000
`define NTU_SUPV_TIME_US    20000

`endif

// [logic/ntu_pkg.sv]
// Types of the NT-side U activation state machine.
package ntu_pkg;

  typedef enum logic [4:0] {
    ntu_reset, ntu_deact, ntu_awaked, ntu_alert, ntu_alert1, ntu_ec_train, ntu_ec_train1,
    ntu_eq_train, ntu_wait_sf, ntu_sync1, ntu_sync2, ntu_wait_act, ntu_transp, ntu_err_st,
    ntu_pend_st, ntu_pend_u, ntu_pend_rxr, ntu_rx_reset, ntu_pend_tim, ntu_test,
    ntu_ec_train_al, ntu_wait_sf_al, ntu_ana_loop
  } ntu_state_t;

  typedef enum logic [2:0] {
    ntu_ls_silence, ntu_ls_nt_tone, ntu_ls_train1, ntu_ls_train2,
    ntu_ls_sync3, ntu_ls_sync3t, ntu_ls_pulses
  } ntu_line_t;

endpackage : ntu_pkg

// [logic/ntu_sync.sv]
// Two-stage synchroniser for a group of asynchronous level inputs.
module ntu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : ntu_sync

// [testbench/ntu_sva.sv]
// Port assertions for the NT activation state machine.
`include "ntu_defs.svh"
module ntu_sva
  import ntu_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  // Inputs
  input wire logic [3:0] ds_cmd_in,
  input wire logic       loopback_b_channels_in,
  // Outputs
  input wire ntu_line_t  line_signal_out,
  input wire logic [3:0] ci_ind_out,
  input wire logic       activity_bit_out,
  input wire logic       downstream_activity_bit_out,
  input wire logic       data_all_ones_out,
  input wire logic       power_down_out,
  input wire logic       adapt_freeze_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Repetitions of four or five cover the two sync flops plus the output register.
  a_ones_idle: assert property (ci_ind_out inside {`NTU_IND_DR, `NTU_IND_DC} |-> data_all_ones_out)
    else $error("data not all ones");
  a_loop_sync_tx: assert property (loopback_b_channels_in [*4] ##0 line_signal_out inside {ntu_ls_sync3, ntu_ls_sync3t}
    |-> line_signal_out == ntu_ls_sync3t) else $error("loopback line signal wrong");
  a_loop_ci_code: assert property (loopback_b_channels_in [*4] |-> !(ci_ind_out inside {`NTU_IND_AR, `NTU_IND_AI}))
    else $error("plain code under loopback");
  a_norm_ci_code: assert property (!loopback_b_channels_in [*4] |-> !(ci_ind_out inside {`NTU_IND_ARL, `NTU_IND_AIL}))
    else $error("loop code without loopback");
  a_sai_quiet: assert property ((ds_cmd_in inside {`NTU_CMD_DI, `NTU_CMD_TIM}) [*5] |-> !downstream_activity_bit_out)
    else $error("activity bit not zero");
  a_sai_active: assert property (!(ds_cmd_in inside {`NTU_CMD_DI, `NTU_CMD_TIM}) [*5] |-> downstream_activity_bit_out)
    else $error("activity bit not one");
  a_freeze_train: assert property (adapt_freeze_out |-> line_signal_out == ntu_ls_train1)
    else $error("freeze differs from training");
  a_pdown_silent: assert property (power_down_out |-> line_signal_out == ntu_ls_silence && !activity_bit_out)
    else $error("power down outside deactivated");
  a_pulse_cmd: assert property (line_signal_out == ntu_ls_pulses |-> $past(ds_cmd_in, 3) == `NTU_CMD_SSP)
    else $error("pulses without command");
  a_rise_act_sync: assert property ($rose(activity_bit_out) |-> line_signal_out inside {ntu_ls_sync3, ntu_ls_sync3t})
    else $error("activity rose while unsynchronised");
endmodule : ntu_sva

// [testbench/ntu_ds_model.sv]
// Behavioural downstream device answering the indication channel.
`include "ntu_defs.svh"
module ntu_ds_model (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // Indication in, command out
  input  wire logic [3:0] ci_in,
  input  wire logic       ovr_en_in,
  input  wire logic [3:0] ovr_cmd_in,
  output logic      [3:0] ds_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ds_cmd_out <= `NTU_CMD_DI;
    end else if (ovr_en_in) begin
      ds_cmd_out <= ovr_cmd_in;
    end else if (ci_in == `NTU_IND_DR || ci_in == `NTU_IND_DC) begin
      ds_cmd_out <= `NTU_CMD_DI;
    end else if (ci_in == `NTU_IND_AR || ci_in == `NTU_IND_ARL) begin
      ds_cmd_out <= `NTU_CMD_AI;
    end else if (ds_cmd_out == `NTU_CMD_SSP || ds_cmd_out == `NTU_CMD_EI1) begin
      ds_cmd_out <= `NTU_CMD_DI;
    end
  end
endmodule : ntu_ds_model

// [testbench/tb_top.sv]
// Self-checking bench for the NT activation state machine.
`include "ntu_defs.svh"
module tb_top
  import ntu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 0, rst_in = 1, rd = 0, wr = 0, lbk = 0, u_only_activation_bit = 0, act = 0, ec = 0, tr = 0, sf = 0, ovr = 0;
  logic wk = 0, lvl = 1, framing_loss = 0, ltd = 0;
  logic [3:0] adr = 0, be = 0, ovc = 0, cmd, ci;
  logic [31:0] wd = 0, rdat, q;
  logic wq, ab, downstream_activity_bit, ones, pd, rxr, frz;
  ntu_line_t ln;
  int err_total = 0, n_checks = 0, cyc = 0;
  logic [3:0] tbl [6] = '{`NTU_CMD_TIM, `NTU_CMD_SSP, `NTU_CMD_EI1, `NTU_CMD_AR, `NTU_CMD_AI, `NTU_CMD_DI};
  always #2.5 sys_clk_in = ~sys_clk_in;
  ntu_act_sm #(.LSU_CYCLES(20), .FRAME_CYCLES(10), .TONE_CYCLES(10), .HOLD_CYCLES(10), .SUPV_CYCLES(2000)) i_ntu_act_sm (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .lt_wake_tone_in(wk), .signal_level_in(lvl), .framing_loss_in(framing_loss), .ec_converged_in(ec),
    .lt_training_in(tr), .superframe_in(sf), .u_only_activation_bit_in(u_only_activation_bit), .act_bit_rx_in(act),
    .lt_deact_in(ltd), .loopback_b_channels_in(lbk), .ds_cmd_in(cmd), .line_signal_out(ln), .ci_ind_out(ci),
    .activity_bit_out(ab), .downstream_activity_bit_out(downstream_activity_bit), .data_all_ones_out(ones), .power_down_out(pd),
    .rx_reset_out(rxr), .adapt_freeze_out(frz));
  ntu_ds_model i_ntu_ds_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ci_in(ci), .ovr_en_in(ovr),
    .ovr_cmd_in(ovc), .ds_cmd_out(cmd));
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // A write with no byte lane enabled is issued to prove that it is dropped.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge sys_clk_in);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    be <= b;
    do @(posedge sys_clk_in); while (wq !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic wt(input logic sel, input logic [3:0] v);
    for (int i = 0; i < 400 && (sel ? ci : {1'b0, ln}) !== v; i++) @(negedge sys_clk_in);
    chk(sel ? ci : {1'b0, ln}, v);
  endtask : wt
  task automatic run(input logic sim);
    logic [3:0] c;
    @(posedge sys_clk_in);
    rst_in <= 1;
    {wk, ltd, framing_loss, lvl} <= 4'h1;
    ovr <= 1;
    ovc <= `NTU_CMD_SSP;
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 0;
    wt(0, ntu_ls_pulses);
    ovr <= 0;
    bus(1, `NTU_OFS_CTRL, {30'h0, 1'b1, sim}, 4'h1);
    bus(1, `NTU_OFS_CTRL, 32'h0, 4'h0);
    bus(0, `NTU_OFS_CTRL, 32'h0, 4'hf);
    chk(q, {30'h0, 1'b1, sim});
    bus(0, 4'h8, 32'h0, 4'hf);
    chk(q, 32'h0);
    wt(0, ntu_ls_nt_tone);
    chk(ci, `NTU_IND_PU);
    wt(0, ntu_ls_train1);
    chk(ci, sim ? `NTU_IND_PU : `NTU_IND_DC);
    @(posedge sys_clk_in) {ec, tr} <= 2'b11;
    wt(0, ntu_ls_train2);
    @(posedge sys_clk_in) {sf, u_only_activation_bit} <= 2'b11;
    wt(1, `NTU_IND_AR);
    chk(ln, ntu_ls_sync3);
    chk(ones, 1);
    @(posedge sys_clk_in) act <= 1;
    wt(1, `NTU_IND_AI);
    chk({ones, ab}, 2'b01);
    ovr <= 1;
    ovc <= `NTU_CMD_EI1;
    wt(1, `NTU_IND_AR);
    chk(ab, 0);
    ovr <= 0;
    wt(1, `NTU_IND_AI);
    @(posedge sys_clk_in) lbk <= 1;
    wt(1, `NTU_IND_AIL);
    chk(ln, ntu_ls_sync3t);
    @(posedge sys_clk_in) lbk <= 0;
    wt(1, `NTU_IND_AI);
    chk(ln, ntu_ls_sync3t);
    @(posedge sys_clk_in) u_only_activation_bit <= 0;
    wt(1, `NTU_IND_DR);
    chk(ab, 1);
    for (int k = 0; k < 6; k++) begin
      c = tbl[$urandom % 6];
      @(posedge sys_clk_in);
      ovr <= 1;
      ovc <= c;
      repeat (6) @(negedge sys_clk_in);
      chk(downstream_activity_bit, !(c inside {`NTU_CMD_DI, `NTU_CMD_TIM}));
    end
    // Standard run leaves through the line deactivation path, simplified through framing loss.
    @(posedge sys_clk_in) {ovr, ec, tr, sf, act, ltd, framing_loss, lvl} <= {5'h0, !sim, sim, 1'b0};
    wt(0, ntu_ls_silence);
    chk(ci, sim ? `NTU_IND_DR : `NTU_IND_DC);
    wt(1, `NTU_IND_DR);
    chk(rxr, 0);
    @(posedge sys_clk_in) wk <= 1;
    wt(0, ntu_ls_nt_tone);
    chk(ci, sim ? `NTU_IND_PU : `NTU_IND_DC);
  endtask : run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h88a14a3f));
    run(0);
    run(1);
    conclude();
  end
endmodule : tb_top
bind ntu_act_sm ntu_sva i_ntu_sva (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ds_cmd_in(ds_cmd_in),
  .loopback_b_channels_in(loopback_b_channels_in), .line_signal_out(line_signal_out), .ci_ind_out(ci_ind_out),
  .activity_bit_out(activity_bit_out), .downstream_activity_bit_out(downstream_activity_bit_out),
  .data_all_ones_out(data_all_ones_out), .power_down_out(power_down_out), .adapt_freeze_out(adapt_freeze_out));
